// File: bench/gpm_periph.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// pins and far-side peripherals
module gpm_periph (
   input  wire logic       clock,
   input  wire logic [5:0] bidirPinOut,
   input  wire logic [5:0] bidirPinOe,
   input  wire logic       sdaPinOut,
   input  wire logic       sdaPinOe,
   input  wire logic [5:0] extVal,
   input  wire logic [5:0] extEn,
   output logic      [5:0] bidirPinIn,
   output logic            sdaPinIn
);
   logic [5:0] lastQ = 6'h00;
   // floating lines 1 to 5 toggle so a stale level never reads as valid; floating line 0 reads low
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (bidirPinOe[i]) bidirPinIn[i] = bidirPinOut[i];
         else if (extEn[i]) bidirPinIn[i] = extVal[i];
         else if (i == 0) bidirPinIn[i] = 1'b0;
         else bidirPinIn[i] = ~lastQ[i];
      end
      sdaPinIn = sdaPinOe ? sdaPinOut : 1'b1;
   end
   always @(posedge clock) lastQ <= bidirPinIn;
endmodule // gpm_periph
`default_nettype wire

// File: bench/gpm_pin_mux_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks
module gpm_pin_mux_chk (
   input wire logic       clock,
   input wire logic       rstn,
   input wire logic [3:0] outPin,
   input wire logic [5:0] bidirPinOe,
   input wire logic [5:0] bidirPinOut,
   input wire logic [5:0] bidirDir,
   input wire logic [5:0] bidirVal,
   input wire logic [3:0] outVal,
   input wire logic       selAuxRts,
   input wire logic       selSpiEn,
   input wire logic       spiEnN,
   input wire logic       atFirmware,
   input wire logic       ringVal,
   input wire logic       carrierVal,
   input wire logic       twoWireMode,
   input wire logic       sdaOut,
   input wire logic       sdaOe,
   input wire logic       sdaPinOe,
   input wire logic       sdaPinOut,
   input wire logic       auxTxdLevel,
   input wire logic       inOnlyLevel,
   input wire logic       serTick,
   input wire logic       serRun,
   input wire logic [5:0] spiHalfDiv
);
   wire half4 = serRun && !twoWireMode && spiHalfDiv == 6'h04;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   resetPins_a: assert property (disable iff (1'b0)
      (!rstn ##1 !rstn) |-> outPin == 4'hd && bidirPinOe == 6'h00)
      else $error("pin state in reset");
   rtsNoDrive_a: assert property (selAuxRts |=> !bidirPinOe[5])
      else $error("line 5 driven");
   fwKeep_a: assert property (atFirmware |=>
      bidirPinOut[3:2] == $past({carrierVal, ringVal})) else $error("firmware lines");
   gpLine_a: assert property (1'b1 |=> bidirPinOe[4] == $past(bidirDir[4]) &&
      (!bidirPinOe[4] || bidirPinOut[4] == $past(bidirVal[4]))) else $error("line 4");
   outLine_a: assert property (1'b1 |=> outPin[1] == $past(outVal[1]))
      else $error("out line 1");
   spiEnable_a: assert property (1'b1 |=>
      outPin[3] == ($past(selSpiEn) ? $past(spiEnN) : $past(outVal[3]))) else $error("enable");
   openDrain_a: assert property (twoWireMode |=> !sdaPinOut &&
      sdaPinOe == ($past(sdaOe) && !$past(sdaOut))) else $error("data drive");
   txdShared_a: assert property (auxTxdLevel == inOnlyLevel)
      else $error("shared input");
   tickSpace_a: assert property (half4 && serTick |=>
      (!serTick || !half4)[*3] ##1 (serTick || !half4)) else $error("tick spacing");
endmodule // gpm_pin_mux_chk
`default_nettype wire

// File: bench/test_general_purpose_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module test_general_purpose_pin_mux;
   logic       clock = 1'b0;
   logic       rstn = 1'b0;
   logic [5:0] bidirDir, bidirVal, spiHalfDiv, extVal, extEn;
   logic [5:0] bidirLevel, bidirPinIn, bidirPinOut, bidirPinOe;
   logic [3:0] outVal, outPin;
   logic [1:0] lampMode;
   logic       selAuxCts, selLamp, selRing, selCarrier, selAuxRts, selSpiAux, selAuxRxd;
   logic       selSpiEn, atFirmware, auxCtsVal, ringVal, carrierVal, spiAuxEnN, spiEnN;
   logic       auxRxdVal, twoWireMode, twoWireFast, serRun, sdaOut, sdaOe, inOnlyPin;
   logic       inOnlyLevel, auxRtsLevel, auxTxdLevel, serTick, sdaLevel, sclOut, sclOe;
   logic       sdaPinOut, sdaPinOe, sdaPinIn;
   int         error_cnt = 0;
   int         n_tests = 0;
   logic [5:0]  spiHalfDiv_t [5] = '{6'h01, 6'h02, 6'h04, 6'h1e, 6'h3f};
   logic [15:0] spiHalfDiv_e [5] = '{16'h2, 16'h2, 16'h4, 16'h1e, 16'h1e};
   gpm_pin_mux uut (.*);
   gpm_periph  pins (.*);
   initial forever #10 clock = ~clock;
   // ==========================================
   // tasks
   task automatic cyc(int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // first pass finds a tick, second counts the spacing
   task automatic period(logic [15:0] exp);
      int n;
      serRun = 1'b1;
      repeat (2) begin
         n = 0;
         do begin
            @(posedge clock);
            #1;
            n++;
         end while (serTick !== 1'b1 && n < 600);
      end
      chk("tick spacing", exp, n[15:0]);
      #2 serRun = 1'b0;
      cyc(2);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========================================
   // sequence
   initial begin
      {bidirDir, bidirVal, extVal, extEn, outVal, lampMode} = '0;
      {selAuxCts, selLamp, selRing, selCarrier, selAuxRts, selSpiAux, selAuxRxd} = '0;
      {selSpiEn, atFirmware, auxCtsVal, ringVal, carrierVal, spiAuxEnN, spiEnN} = '0;
      {auxRxdVal, twoWireMode, twoWireFast, serRun, sdaOut, sdaOe, inOnlyPin} = '0;
      spiHalfDiv = 6'h04;
      cyc(1);
      chk("out reset", 4'hd, outPin);
      chk("enable reset", 6'h00, bidirPinOe);
      chk("clock reset", 1'b1, sclOut);
      cyc(1);
      rstn = 1'b1;
      cyc(6);
      chk("line 0 low", 1'b0, bidirLevel[0]);
      extEn = 6'h01;
      extVal = 6'h01;
      cyc(6);
      chk("line 0 high", 1'b1, bidirLevel[0]);
      extEn = 6'h00;
      bidirDir = 6'h3f;
      bidirVal = 6'h15;
      cyc(6);
      chk("gp enable", 6'h3f, bidirPinOe);
      chk("gp level", 6'h15, bidirLevel);
      bidirVal = 6'h2a;
      atFirmware = 1'b1;
      ringVal = 1'b1;
      cyc(2);
      chk("fw lines", 2'b01, bidirPinOut[3:2]);
      atFirmware = 1'b0;
      selAuxCts = 1'b1;
      auxCtsVal = 1'b1;
      selAuxRts = 1'b1;
      cyc(2);
      chk("cts out", 1'b1, bidirPinOut[0]);
      chk("rts undriven", 1'b0, bidirPinOe[5]);
      extEn = 6'h20;
      extVal = 6'h20;
      inOnlyPin = 1'b1;
      {selSpiAux, selAuxRxd, selSpiEn, outVal} = 7'h7f;
      cyc(6);
      chk("rts level", 1'b1, auxRtsLevel);
      chk("in level", 1'b1, inOnlyLevel);
      chk("out shared", 4'h2, outPin);
      {selSpiAux, selAuxRxd, selSpiEn, outVal} = 7'h05;
      cyc(2);
      chk("out gp", 4'h5, outPin);
      selLamp = 1'b1;
      cyc(3);
      chk("lamp off", 2'b10, {bidirPinOe[1], bidirPinOut[1]});
      lampMode = 2'h1;
      cyc(3);
      chk("lamp steady", 1'b1, bidirPinOut[1]);
      lampMode = 2'h0;
      cyc(3);
      lampMode = 2'h2;
      cyc(3);
      chk("lamp slow on", 1'b1, bidirPinOut[1]);
      lampMode = 2'h0;
      cyc(3);
      lampMode = 2'h3;
      cyc(3);
      chk("lamp fast on", 1'b1, bidirPinOut[1]);
      foreach (spiHalfDiv_t[i]) begin
         spiHalfDiv = spiHalfDiv_t[i];
         period(spiHalfDiv_e[i]);
      end
      twoWireMode = 1'b1;
      sdaOe = 1'b1;
      cyc(2);
      chk("data low", 2'b10, {sdaPinOe, sdaPinOut});
      period(16'h0104);
      twoWireFast = 1'b1;
      period(16'h003e);
      wrap_up;
   end
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      wrap_up;
   end
endmodule // test_general_purpose_pin_mux
bind gpm_pin_mux gpm_pin_mux_chk chk (.*);
`default_nettype wire

// File: hw/gpm_lamp.v
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defs.vh"

// ==========================================
// activity lamp pattern generator
module gpm_lamp (
   input  wire       clock,
   input  wire       rstn,
   input  wire [1:0] lampMode,
   output reg        lampOn
);
   localparam integer ON_I     = `GPM_LAMP_ON_MS * `GPM_MS_CYCLES;
   localparam integer SLOW_I   = `GPM_LAMP_SLOW_MS * `GPM_MS_CYCLES;
   localparam integer FAST_I   = `GPM_LAMP_FAST_MS * `GPM_MS_CYCLES;
   localparam [26:0]  ON_CYC   = ON_I[26:0];
   localparam [26:0]  SLOW_CYC = SLOW_I[26:0];
   localparam [26:0]  FAST_CYC = FAST_I[26:0];

   reg [`GPM_LAMP_W-1:0] cnt_q;
   reg                   phaseOn_q;
   wire [26:0]           offCyc = (lampMode == `GPM_LAMP_FAST) ? FAST_CYC : SLOW_CYC;
   wire [26:0]           limit  = phaseOn_q ? ON_CYC : offCyc;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_q     <= {`GPM_LAMP_W{1'b0}};
         phaseOn_q <= 1'b0;
         lampOn    <= 1'b0;
      end else begin
         case (lampMode)
            `GPM_LAMP_OFF: begin
               cnt_q     <= {`GPM_LAMP_W{1'b0}};
               phaseOn_q <= 1'b1;
               lampOn    <= 1'b0; // see R15
            end
            `GPM_LAMP_STEADY: begin
               cnt_q     <= {`GPM_LAMP_W{1'b0}};
               phaseOn_q <= 1'b1;
               lampOn    <= 1'b1; // see R15
            end
            default: begin
               // 200 ms on, then 2 s or 600 ms off
               if (cnt_q >= limit - 27'h1) begin
                  cnt_q     <= {`GPM_LAMP_W{1'b0}};
                  phaseOn_q <= ~phaseOn_q; // see R15
               end else begin
                  cnt_q <= cnt_q + 27'h1;
               end
               lampOn <= phaseOn_q;
            end
         endcase
      end
   end
endmodule // gpm_lamp

`default_nettype wire

// File: hw/gpm_pin_mux.v
// Functional notes
// R1: six bidirectional lines, four output lines and one input-only line are provided.
// R2: bidirectional line 0 is undriven from reset, leaving only its weak pull-down.
// R3: at reset output line 1 drives low and output lines 0, 2 and 3 drive high.
// R4: bidirectional lines 1 to 5 reset as inputs with drivers off.
// R5: the input-only line has a reset pull-down and shares its pin with aux transmit data in.
// R6: under command-interpreter firmware lines 2 and 3 are kept for the main serial port.
// R7: the serial-peripheral clock is programmable from 812 kHz to 13 MHz; half counts 2 to 30 at 50 MHz give 833 kHz to 12.5 MHz.
// R8: the peripheral clock/data pins share with the two-wire bus and reset with pull-ups.
// R9: the two-wire bus clock is either 96 kHz or 400 kHz.
// R10: second chip enable shares output line 0, main enable output line 3, both reset high.
// R11: aux clear-to-send shares line 0, aux request-to-send shares line 5.
// R12: aux receive data shares output line 2 and resets high.
// R13: carrier detect shares line 3, ring indicator shares line 2, both reset undriven.
// R14: bidirectional line 1 shares its pin with the activity lamp and resets undriven.
// R15: the lamp is low when off, steady when unregistered, else 200 ms on and 2 s or 600 ms off.
// R16: each shared pin has a function select and only the chosen function drives it.
// R17: each bidirectional line has direction and value controls and a readable input.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defs.vh"

module gpm_pin_mux (
   input  wire                      clock,
   input  wire                      rstn,
   // general-purpose controls
   input  wire [`GPM_BIDIR_N-1:0]   bidirDir,
   input  wire [`GPM_BIDIR_N-1:0]   bidirVal,
   input  wire [3:0]                outVal,
   output reg  [`GPM_BIDIR_N-1:0]   bidirLevel,
   output reg                       inOnlyLevel,
   // function selects, high picks the peripheral function
   input  wire                      selAuxCts,
   input  wire                      selLamp,
   input  wire                      selRing,
   input  wire                      selCarrier,
   input  wire                      selAuxRts,
   input  wire                      selSpiAux,
   input  wire                      selAuxRxd,
   input  wire                      selSpiEn,
   input  wire                      atFirmware,
   // peripheral sources
   input  wire                      auxCtsVal,
   input  wire                      ringVal,
   input  wire                      carrierVal,
   input  wire                      spiAuxEnN,
   input  wire                      spiEnN,
   input  wire                      auxRxdVal,
   input  wire [1:0]                lampMode,
   output reg                       auxRtsLevel,
   output reg                       auxTxdLevel,
   // serial clock and data
   input  wire                      twoWireMode,
   input  wire                      twoWireFast,
   input  wire [5:0]                spiHalfDiv,
   input  wire                      serRun,
   input  wire                      sdaOut,
   input  wire                      sdaOe,
   output reg                       serTick,
   output reg                       sdaLevel,
   output reg                       sclOut,
   output reg                       sclOe,
   output reg                       sdaPinOut,
   output reg                       sdaPinOe,
   // pins
   input  wire [`GPM_BIDIR_N-1:0]   bidirPinIn,
   output reg  [`GPM_BIDIR_N-1:0]   bidirPinOut,
   output reg  [`GPM_BIDIR_N-1:0]   bidirPinOe,
   output reg  [3:0]                outPin,
   input  wire                      inOnlyPin,
   input  wire                      sdaPinIn
);

   // ==========================================
   // pin input synchronisers
   wire [`GPM_BIDIR_N+1:0] syncIn;

   gpm_sync #(.W(`GPM_BIDIR_N + 2)) uSync (
      .clock  (clock),
      .rstn   (rstn),
      .async  ({sdaPinIn, inOnlyPin, bidirPinIn}),
      .synced (syncIn)
   );

   // ==========================================
   // lamp pattern
   wire lampOn;

   gpm_lamp uLamp (
      .clock    (clock),
      .rstn     (rstn),
      .lampMode (lampMode),
      .lampOn   (lampOn)
   );

   // ==========================================
   // serial clock divider
   function [5:0] clampSpi;
      input [5:0] req;
      begin
         if (req < `GPM_SPI_HALF_MIN) begin
            clampSpi = `GPM_SPI_HALF_MIN;
         end else if (req > `GPM_SPI_HALF_MAX) begin
            clampSpi = `GPM_SPI_HALF_MAX;
         end else begin
            clampSpi = req;
         end
      end
   endfunction

   reg [`GPM_TW_DIV_W-1:0] divCnt_q;
   reg                     serClk_q;
   wire [`GPM_TW_DIV_W-1:0] halfLim =
      twoWireMode ? (twoWireFast ? `GPM_TW_HALF_FAST : `GPM_TW_HALF_SLOW) // see R9
                  : {3'h0, clampSpi(spiHalfDiv)}; // see R7

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         divCnt_q <= {`GPM_TW_DIV_W{1'b0}};
         serClk_q <= 1'b1;
         serTick  <= 1'b0;
      end else if (!serRun) begin
         // idle clock parks high, matching the pull-up level
         divCnt_q <= {`GPM_TW_DIV_W{1'b0}};
         serClk_q <= 1'b1;
         serTick  <= 1'b0;
      end else if (divCnt_q >= halfLim - 9'h1) begin
         divCnt_q <= {`GPM_TW_DIV_W{1'b0}};
         serClk_q <= ~serClk_q;
         serTick  <= 1'b1;
      end else begin
         divCnt_q <= divCnt_q + 9'h1;
         serTick  <= 1'b0;
      end
   end

   // ==========================================
   // pin drive
   integer i;
   reg [`GPM_BIDIR_N-1:0] pOut;
   reg [`GPM_BIDIR_N-1:0] pOe;
   reg [3:0]              oPin;

   always @* begin
      pOut = bidirVal; // see R17
      pOe  = bidirDir; // see R17
      // aux clear-to-send on line 0
      if (selAuxCts) begin
         pOut[0] = auxCtsVal; // see R11
         pOe[0]  = 1'b1; // see R16
      end
      if (selLamp) begin
         pOut[1] = lampOn; // see R14
         pOe[1]  = 1'b1; // see R16
      end
      // lines 2 and 3 forced to serial-port use under command firmware
      if (selRing || atFirmware) begin
         pOut[2] = ringVal; // see R13
         pOe[2]  = 1'b1; // see R6
      end
      if (selCarrier || atFirmware) begin
         pOut[3] = carrierVal; // see R13
         pOe[3]  = 1'b1; // see R6
      end
      // request-to-send is an input, so line 5 is never driven in that mode
      if (selAuxRts) begin
         pOut[5] = 1'b0;
         pOe[5]  = 1'b0; // see R11
      end
      oPin    = outVal;
      oPin[0] = selSpiAux ? spiAuxEnN : outVal[0]; // see R10
      oPin[2] = selAuxRxd ? auxRxdVal : outVal[2]; // see R12
      oPin[3] = selSpiEn  ? spiEnN    : outVal[3]; // see R10
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bidirPinOut <= {`GPM_BIDIR_N{1'b0}};
         bidirPinOe  <= {`GPM_BIDIR_N{1'b0}}; // see R2 see R4
         outPin      <= `GPM_OUT_RESET; // see R3 see R10 see R12
         sclOut      <= 1'b1;
         sclOe       <= 1'b0; // see R8
         sdaPinOut   <= 1'b1;
         sdaPinOe    <= 1'b0; // see R8
         bidirLevel  <= {`GPM_BIDIR_N{1'b0}};
         inOnlyLevel <= 1'b0;
         auxRtsLevel <= 1'b0;
         auxTxdLevel <= 1'b0;
         sdaLevel    <= 1'b0;
      end else begin
         bidirPinOut <= pOut; // see R1
         bidirPinOe  <= pOe; // see R16
         outPin      <= oPin; // see R1
         sclOut      <= serClk_q;
         // two-wire clock is open drain: only pull low
         sclOe       <= twoWireMode ? (serRun & ~serClk_q) : serRun; // see R8
         sdaPinOut   <= twoWireMode ? 1'b0 : sdaOut;
         sdaPinOe    <= twoWireMode ? (sdaOe & ~sdaOut) : sdaOe; // see R8
         bidirLevel  <= syncIn[`GPM_BIDIR_N-1:0]; // see R17
         auxRtsLevel <= selAuxRts ? syncIn[5] : 1'b0; // see R11
         inOnlyLevel <= syncIn[`GPM_BIDIR_N]; // see R5
         auxTxdLevel <= syncIn[`GPM_BIDIR_N]; // see R5
         sdaLevel    <= syncIn[`GPM_BIDIR_N+1];
      end
   end
endmodule // gpm_pin_mux

`default_nettype wire

// File: hw/gpm_sync.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// three-stage synchroniser, change taken when stages two and three agree
module gpm_sync #(
   parameter W = 1
) (
   input  wire         clock,
   input  wire         rstn,
   input  wire [W-1:0] async,
   output reg  [W-1:0] synced
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   integer i;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_q   <= {W{1'b0}};
         s2_q   <= {W{1'b0}};
         s3_q   <= {W{1'b0}};
         synced <= {W{1'b0}};
      end else begin
         s1_q <= async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (i = 0; i < W; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
               synced[i] <= s3_q[i];
            end
         end
      end
   end
endmodule // gpm_sync

`default_nettype wire

// File: include/gpm_defs.vh
`ifndef GPM_DEFS_VH
`define GPM_DEFS_VH

// ==========================================
// clock
`define GPM_CLK_HZ          50000000

// ==========================================
// serial-peripheral clock range
`define GPM_SPI_MIN_HZ      812000
`define GPM_SPI_MAX_HZ      13000000
`define GPM_SPI_DIV_W       6
// half-period counts at 50 MHz, min rounds up, max rounds down
`define GPM_SPI_HALF_MIN    6'h02
`define GPM_SPI_HALF_MAX    6'h1e

// ==========================================
// two-wire bus clock choices
`define GPM_TW_SLOW_HZ      96000
`define GPM_TW_FAST_HZ      400000
`define GPM_TW_DIV_W        9
`define GPM_TW_HALF_SLOW    9'h104
`define GPM_TW_HALF_FAST    9'h03e

// ==========================================
// activity lamp timing
`define GPM_LAMP_ON_MS      200
`define GPM_LAMP_SLOW_MS    2000
`define GPM_LAMP_FAST_MS    600
`define GPM_LAMP_W          27
`define GPM_MS_CYCLES       50000

// lamp modes
`define GPM_LAMP_OFF        2'h0
`define GPM_LAMP_STEADY     2'h1
`define GPM_LAMP_SLOW       2'h2
`define GPM_LAMP_FAST       2'h3

// ==========================================
// reset values
`define GPM_OUT_RESET       4'hd
`define GPM_BIDIR_N         6

`endif
